// ### rtl/dgc_pkg.sv
// constants and types for the dual multipurpose pin control block
package dgc_pkg;

  typedef logic [1:0] dgc_mode_t;

  localparam int DGC_NUM_PINS = 2;

  // configuration space offsets, pin 1 then pin 2
  localparam logic [7:0] DGC_PIN1_OFS = 8'h89;
  localparam logic [7:0] DGC_PIN2_OFS = 8'h8a;

  localparam logic [7:0] DGC_CTRL_RST = 8'h80;

  // field positions in each control register
  localparam int DGC_MODE_HI = 7;
  localparam int DGC_MODE_LO = 6;
  localparam int DGC_RSVD_HI = 5;
  localparam int DGC_IRQ_EN = 4;
  localparam int DGC_FLAG = 3;
  localparam int DGC_RSVD_LO = 2;
  localparam int DGC_OUT_VAL = 1;
  localparam int DGC_IN_VAL = 0;

  // mode codes
  localparam dgc_mode_t DGC_MODE_ALT = 2'h0;
  localparam dgc_mode_t DGC_MODE_ALT2 = 2'h1;
  localparam dgc_mode_t DGC_MODE_INPUT = 2'h2;
  localparam dgc_mode_t DGC_MODE_OUTPUT = 2'h3;

  localparam dgc_mode_t DGC_MODE_RST = DGC_CTRL_RST[DGC_MODE_HI:DGC_MODE_LO];

  // edges after reset before change detection is trusted
  localparam int DGC_SYNC_PRIME = 3;

endpackage : dgc_pkg

// ### rtl/dgc_pin_sync.sv
// two-stage pin synchroniser with change detection
`timescale 1ns/1ns
`default_nettype none
module dgc_pin_sync
  import dgc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw pin level
  input wire logic pin_raw,
  // synchronised level and change strobe
  output logic level,
  output logic toggled
);

  logic meta_ff;
  logic level_ff;
  logic prev_ff;
  logic [DGC_SYNC_PRIME-1:0] prime_ff;

  // two flops before any logic reads the pin
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_ff <= 1'b0;
      level_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pin_raw;
      level_ff <= meta_ff;
    end
  end

  // previous level for edge compare
  always_ff @(posedge clk)
  begin
    if (rst)
      prev_ff <= 1'b0;
    else
      prev_ff <= level_ff;
  end

  // suppress the false edge while the chain fills after reset
  always_ff @(posedge clk)
  begin
    if (rst)
      prime_ff <= '0;
    else
      prime_ff <= {prime_ff[DGC_SYNC_PRIME-2:0], 1'b1};
  end

  assign level = level_ff;
  assign toggled = prime_ff[DGC_SYNC_PRIME-1] & (level_ff ^ prev_ff);

endmodule : dgc_pin_sync
`default_nettype wire

// ### rtl/dgc_top.sv
// dual multipurpose pin control and status registers
`timescale 1ns/1ns
`default_nettype none
module dgc_top
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration space byte access
  input wire logic cfg_sel,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // alternate functions
  input wire logic socket1_activity_led,
  input wire logic video_port_enabled_status,
  output logic bus_lock_n,
  // status change requests
  output logic socket_status_change_a,
  output logic socket_status_change_b,
  // multipurpose pin 1
  input wire logic multipurpose_pin1_in,
  output logic multipurpose_pin1_out,
  output logic multipurpose_pin1_oe,
  // multipurpose pin 2
  input wire logic multipurpose_pin2_in,
  output logic multipurpose_pin2_out,
  output logic multipurpose_pin2_oe
);
  import dgc_pkg::*;

  default clocking dgc_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [DGC_NUM_PINS-1:0] pin_raw;
  logic [DGC_NUM_PINS-1:0] in_level;
  logic [DGC_NUM_PINS-1:0] in_toggle;
  logic [DGC_NUM_PINS-1:0] wr_hit;
  logic [DGC_NUM_PINS-1:0] rd_hit;
  logic [DGC_NUM_PINS-1:0] irq_en_ff;
  logic [DGC_NUM_PINS-1:0] flag_ff;
  logic [DGC_NUM_PINS-1:0] out_val_ff;
  logic [7:0] reg_image [DGC_NUM_PINS];
  dgc_mode_t mode_ff [DGC_NUM_PINS];
  logic [7:0] pin_ofs [DGC_NUM_PINS];

  logic nxt_pin1_out;
  logic nxt_pin1_oe;
  logic nxt_pin2_out;
  logic nxt_pin2_oe;
  logic pin1_out_ff;
  logic pin1_oe_ff;
  logic pin2_out_ff;
  logic pin2_oe_ff;
  logic lock_n_ff;
  logic csc_a_ff;
  logic csc_b_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [7:0] nxt_rdata;

  assign pin_raw = {multipurpose_pin2_in, multipurpose_pin1_in};
  assign pin_ofs[0] = DGC_PIN1_OFS;
  assign pin_ofs[1] = DGC_PIN2_OFS;

  genvar g;
  generate
    for (g = 0; g < DGC_NUM_PINS; g++)
    begin : g_pin
      dgc_pin_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pin_raw(pin_raw[g]),
        .level(in_level[g]),
        .toggled(in_toggle[g])
      );

      // decode is the same in either function
      assign wr_hit[g] = cfg_sel & cfg_we & (cfg_addr == pin_ofs[g]);
      assign rd_hit[g] = cfg_sel & ~cfg_we & (cfg_addr == pin_ofs[g]);

      // reserved bits read 0, bit 0 is the live pin
      assign reg_image[g] = {mode_ff[g], 1'b0, irq_en_ff[g], flag_ff[g], 1'b0,
                             out_val_ff[g], in_level[g]};

      // writable fields; reserved and input bits ignore writes
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          mode_ff[g] <= DGC_MODE_RST;
          irq_en_ff[g] <= DGC_CTRL_RST[DGC_IRQ_EN];
          out_val_ff[g] <= DGC_CTRL_RST[DGC_OUT_VAL];
        end
        else if (wr_hit[g])
        begin
          mode_ff[g] <= cfg_wdata[DGC_MODE_HI:DGC_MODE_LO];
          irq_en_ff[g] <= cfg_wdata[DGC_IRQ_EN];
          out_val_ff[g] <= cfg_wdata[DGC_OUT_VAL];
        end
      end

      // sticky change flag, set beats write-one clear
      always_ff @(posedge clk)
      begin
        if (rst)
          flag_ff[g] <= DGC_CTRL_RST[DGC_FLAG];
        else if (in_toggle[g] && mode_ff[g] == DGC_MODE_INPUT)
          flag_ff[g] <= 1'b1;
        else if (wr_hit[g] && cfg_wdata[DGC_FLAG])
          flag_ff[g] <= 1'b0;
      end

      a_flag_sets: assert property (
        (in_toggle[g] && mode_ff[g] == DGC_MODE_INPUT) |=> flag_ff[g])
        else $error("change in input mode did not set flag");

      a_flag_holds: assert property (
        (flag_ff[g] && !(wr_hit[g] && cfg_wdata[DGC_FLAG])) |=> flag_ff[g])
        else $error("change flag dropped without write of one");

      a_flag_clears: assert property (
        (wr_hit[g] && cfg_wdata[DGC_FLAG]
         && !(in_toggle[g] && mode_ff[g] == DGC_MODE_INPUT)) |=> !flag_ff[g])
        else $error("write of one did not clear flag");

      a_no_false_flag: assert property (
        (!flag_ff[g] && mode_ff[g] != DGC_MODE_INPUT) |=> !flag_ff[g])
        else $error("flag set outside input mode");

      a_mode_write: assert property (
        wr_hit[g] |=> mode_ff[g] == $past(cfg_wdata[DGC_MODE_HI:DGC_MODE_LO]))
        else $error("mode field did not take written value");
    end
  endgenerate

  // pin 1 drive select
  always_comb
  begin
    nxt_pin1_out = 1'b0;
    nxt_pin1_oe = 1'b0;
    unique case (mode_ff[0])
      DGC_MODE_ALT:
      begin
        nxt_pin1_out = socket1_activity_led;
        nxt_pin1_oe = 1'b1;
      end
      DGC_MODE_ALT2:
      begin
        nxt_pin1_oe = 1'b0;
      end
      DGC_MODE_INPUT:
      begin
        nxt_pin1_oe = 1'b0;
      end
      DGC_MODE_OUTPUT:
      begin
        nxt_pin1_out = out_val_ff[0];
        nxt_pin1_oe = 1'b1;
      end
    endcase
  end

  // pin 2 drive select, lock is an input function
  always_comb
  begin
    nxt_pin2_out = 1'b0;
    nxt_pin2_oe = 1'b0;
    unique case (mode_ff[1])
      DGC_MODE_ALT:
      begin
        nxt_pin2_oe = 1'b0;
      end
      DGC_MODE_ALT2:
      begin
        nxt_pin2_out = video_port_enabled_status;
        nxt_pin2_oe = 1'b1;
      end
      DGC_MODE_INPUT:
      begin
        nxt_pin2_oe = 1'b0;
      end
      DGC_MODE_OUTPUT:
      begin
        nxt_pin2_out = out_val_ff[1];
        nxt_pin2_oe = 1'b1;
      end
    endcase
  end

  // registered pin drivers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin1_out_ff <= 1'b0;
      pin1_oe_ff <= 1'b0;
      pin2_out_ff <= 1'b0;
      pin2_oe_ff <= 1'b0;
    end
    else
    begin
      pin1_out_ff <= nxt_pin1_out;
      pin1_oe_ff <= nxt_pin1_oe;
      pin2_out_ff <= nxt_pin2_out;
      pin2_oe_ff <= nxt_pin2_oe;
    end
  end

  // lock seen on pin 2 only in lock mode, idle high otherwise
  always_ff @(posedge clk)
  begin
    if (rst)
      lock_n_ff <= 1'b1;
    else
      lock_n_ff <= (mode_ff[1] == DGC_MODE_ALT) ? in_level[1] : 1'b1;
  end

  // status change requests follow enable and flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      csc_a_ff <= 1'b0;
      csc_b_ff <= 1'b0;
    end
    else
    begin
      csc_a_ff <= irq_en_ff[0] & flag_ff[0];
      csc_b_ff <= irq_en_ff[1] & flag_ff[1];
    end
  end

  // read mux, unmapped offsets read 0
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (rd_hit[0])
      nxt_rdata = reg_image[0];
    else if (rd_hit[1])
      nxt_rdata = reg_image[1];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= cfg_sel & ~cfg_we;
      if (cfg_sel && !cfg_we)
        rdata_ff <= nxt_rdata;
    end
  end

  assign cfg_rdata = rdata_ff;
  assign cfg_rvalid = rvalid_ff;
  assign bus_lock_n = lock_n_ff;
  assign socket_status_change_a = csc_a_ff;
  assign socket_status_change_b = csc_b_ff;
  assign multipurpose_pin1_out = pin1_out_ff;
  assign multipurpose_pin1_oe = pin1_oe_ff;
  assign multipurpose_pin2_out = pin2_out_ff;
  assign multipurpose_pin2_oe = pin2_oe_ff;

  sequence s_rd_pin1;
    cfg_sel && !cfg_we && cfg_addr == DGC_PIN1_OFS;
  endsequence

  sequence s_rd_pin2;
    cfg_sel && !cfg_we && cfg_addr == DGC_PIN2_OFS;
  endsequence

  sequence s_irq_a_cause;
    irq_en_ff[0] && flag_ff[0];
  endsequence

  a_reset_pin1: assert property (
    $fell(rst) |-> mode_ff[0] == DGC_MODE_INPUT && !irq_en_ff[0] && !flag_ff[0]
                   && !out_val_ff[0])
    else $error("pin 1 register not at reset value");

  a_reset_pin2: assert property (
    $fell(rst) |-> mode_ff[1] == DGC_MODE_INPUT && !irq_en_ff[1] && !flag_ff[1]
                   && !out_val_ff[1])
    else $error("pin 2 register not at reset value");

  a_pin1_led: assert property (
    (mode_ff[0] == DGC_MODE_ALT) |=>
      multipurpose_pin1_oe && multipurpose_pin1_out == $past(socket1_activity_led))
    else $error("pin 1 not driving activity led");

  a_pin1_reserved: assert property (
    (mode_ff[0] == DGC_MODE_ALT2) |=> !multipurpose_pin1_oe)
    else $error("pin 1 driven in reserved mode");

  a_pin2_lock: assert property (
    (mode_ff[1] == DGC_MODE_ALT) |=> !multipurpose_pin2_oe
      && bus_lock_n == $past(in_level[1]))
    else $error("pin 2 lock mode wrong");

  a_pin2_video: assert property (
    (mode_ff[1] == DGC_MODE_ALT2) |=> multipurpose_pin2_oe
      && multipurpose_pin2_out == $past(video_port_enabled_status))
    else $error("pin 2 not driving video status");

  a_out_drive: assert property (
    (mode_ff[0] == DGC_MODE_OUTPUT && mode_ff[1] == DGC_MODE_OUTPUT) |=>
      multipurpose_pin1_oe && multipurpose_pin2_oe
      && multipurpose_pin1_out == $past(out_val_ff[0])
      && multipurpose_pin2_out == $past(out_val_ff[1]))
    else $error("output mode does not drive data bit");

  a_input_float: assert property (
    (mode_ff[0] == DGC_MODE_INPUT) |=> !multipurpose_pin1_oe)
    else $error("pin 1 driven in input mode");

  a_irq_a: assert property (
    s_irq_a_cause |=> socket_status_change_a)
    else $error("socket A status change not raised");

  a_irq_b: assert property (
    !(irq_en_ff[1] && flag_ff[1]) |=> !socket_status_change_b)
    else $error("socket B status change without cause");

  a_read_pin1: assert property (
    s_rd_pin1 |=> cfg_rvalid && !cfg_rdata[DGC_RSVD_HI] && !cfg_rdata[DGC_RSVD_LO]
      && cfg_rdata[DGC_IN_VAL] == $past(in_level[0]))
    else $error("pin 1 read image wrong");

  a_read_pin2: assert property (
    s_rd_pin2 |=> cfg_rvalid && !cfg_rdata[DGC_RSVD_HI] && !cfg_rdata[DGC_RSVD_LO]
      && cfg_rdata[DGC_MODE_HI:DGC_MODE_LO] == $past(mode_ff[1]))
    else $error("pin 2 read image wrong");

endmodule : dgc_top
`default_nettype wire

// ### verif/dgc_pin_partner.sv
// behavioural outside world for the two multipurpose pins
`timescale 1ns/1ns
`default_nettype none
module dgc_pin_partner
(
  // block drive
  input wire logic [1:0] drv_oe,
  input wire logic [1:0] drv_val,
  // outside source
  input wire logic [1:0] ext_val,
  // resolved pin level
  output logic [1:0] pin_level
);
  // block wins while it drives, else the outside source holds the line
  assign pin_level = (drv_oe & drv_val) | (~drv_oe & ext_val);
endmodule : dgc_pin_partner
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the dual multipurpose pin block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dgc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_sel = 1'b0;
  logic cfg_we = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  logic led = 1'b0;
  logic video = 1'b0;
  logic bus_lock_n, csc_a, csc_b;
  logic [1:0] ext_v = 2'b00;
  logic [1:0] oe, out, pin;
  int bad_count = 0;
  int n_tests = 0;

  always #10 clk = ~clk;

  dgc_top dut_u (.clk(clk), .rst(rst), .cfg_sel(cfg_sel), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .socket1_activity_led(led),
    .video_port_enabled_status(video), .bus_lock_n(bus_lock_n),
    .socket_status_change_a(csc_a), .socket_status_change_b(csc_b),
    .multipurpose_pin1_in(pin[0]), .multipurpose_pin1_out(out[0]),
    .multipurpose_pin1_oe(oe[0]), .multipurpose_pin2_in(pin[1]),
    .multipurpose_pin2_out(out[1]), .multipurpose_pin2_oe(oe[1]));

  dgc_pin_partner pp_u (.drv_oe(oe), .drv_val(out), .ext_val(ext_v), .pin_level(pin));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask : ticks

  // one-cycle write strobe, launched at a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_sel = 1'b1;
    cfg_we = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_sel = 1'b0;
    cfg_we = 1'b0;
    // idle cycle so the next access never re-raises the strobe in this step
    @(negedge clk);
  endtask : wr

  // function 0 is the only path there is
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    int i;
    cfg_sel = 1'b1;
    cfg_we = 1'b0;
    cfg_addr = a;
    @(negedge clk);
    cfg_sel = 1'b0;
    for (i = 0; i < 4 && cfg_rvalid !== 1'b1; i++)
      @(negedge clk);
    chk1(cfg_rvalid, 1'b1, "read answer");
    chk8(cfg_rdata, exp, what);
    // idle cycle so the next access never re-raises the strobe in this step
    @(negedge clk);
  endtask : rd

  task automatic t_reset();
    rd(DGC_PIN1_OFS, DGC_CTRL_RST, "pin1 reset value");
    rd(DGC_PIN2_OFS, DGC_CTRL_RST, "pin2 reset value");
    chk1(oe[0] | oe[1], 1'b0, "no drive after reset");
    wr(8'h88, 8'hff);
    rd(8'h88, 8'h00, "unmapped offset");
    wr(DGC_PIN1_OFS, 8'ha4);
    rd(DGC_PIN1_OFS, 8'h80, "reserved bits");
    $display("test reset done");
  endtask : t_reset

  task automatic t_input(input int p);
    logic [7:0] a;
    logic v;
    a = (p == 1) ? DGC_PIN2_OFS : DGC_PIN1_OFS;
    wr(a, 8'h98);
    ticks(6);
    wr(a, 8'h98);
    ext_v[p] = ~ext_v[p];
    v = ext_v[p];
    ticks(6);
    rd(a, {7'h4c, v}, "change flag set");
    chk1((p == 1) ? csc_b : csc_a, 1'b1, "status change up");
    wr(a, 8'h90);
    ticks(2);
    rd(a, {7'h4c, v}, "flag kept on 0");
    wr(a, 8'h80);
    ticks(2);
    rd(a, {7'h44, v}, "flag kept, irq off");
    chk1((p == 1) ? csc_b : csc_a, 1'b0, "no status change when off");
    wr(a, 8'h98);
    ticks(2);
    rd(a, {7'h48, v}, "flag cleared on 1");
    chk1((p == 1) ? csc_b : csc_a, 1'b0, "status change down");
    $display("test input pin %0d done", p + 1);
  endtask : t_input

  task automatic t_output(input int p);
    logic [7:0] a;
    a = (p == 1) ? DGC_PIN2_OFS : DGC_PIN1_OFS;
    wr(a, 8'he6);
    ticks(6);
    chk1(oe[p], 1'b1, "output enable");
    chk1(out[p], 1'b1, "output high");
    rd(a, 8'hc3, "output readback");
    wr(a, 8'hc0);
    ticks(6);
    chk1(out[p], 1'b0, "output low");
    rd(a, 8'hc0, "no flag in output mode");
    $display("test output pin %0d done", p + 1);
  endtask : t_output

  task automatic t_alt();
    wr(DGC_PIN1_OFS, 8'h00);
    led = 1'b1;
    ticks(3);
    chk1(oe[0], 1'b1, "led drives pin1");
    chk1(out[0], 1'b1, "led high");
    led = 1'b0;
    ticks(3);
    chk1(out[0], 1'b0, "led low");
    wr(DGC_PIN1_OFS, 8'h40);
    ticks(3);
    chk1(oe[0], 1'b0, "reserved mode idle");
    ext_v[1] = 1'b0;
    wr(DGC_PIN2_OFS, 8'h00);
    ticks(6);
    chk1(oe[1], 1'b0, "lock mode not driven");
    chk1(bus_lock_n, 1'b0, "lock asserted");
    ext_v[1] = 1'b1;
    ticks(6);
    chk1(bus_lock_n, 1'b1, "lock released");
    video = 1'b1;
    wr(DGC_PIN2_OFS, 8'h40);
    ticks(3);
    chk1(oe[1], 1'b1, "video status drives");
    chk1(out[1], 1'b1, "video status high");
    $display("test alternate modes done");
  endtask : t_alt

  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_input(0);
    t_input(1);
    t_output(0);
    t_output(1);
    t_alt();
    report_and_stop();
  end

  // watchdog, far beyond the roughly 165 cycles the tests need
  initial
  begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
